// [src/rflk_pkg.sv]
/*
 * Package for the reference input frequency and lock enable block:
 * register indices, field positions, reset values, carrier structs and
 * the frequency code decode function.
 * Assumes a 32-bit classic Wishbone slave with 8-bit registers, each
 * register at byte address four times its index.
 */
package rflk_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes

    localparam int NUM_INPUTS = 8;
    localparam int REG_WIDTH = 8;
    localparam int ADR_WIDTH = 10;
    localparam int HZ_WIDTH = 28;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is index times four

    localparam logic [7:0] IDX_SRC_CFG_FIRST = 8'h20;
    localparam logic [7:0] IDX_SRC_CFG_LAST = 8'h27;
    localparam logic [7:0] IDX_PARTNER_MASK_LOW = 8'h30;
    localparam logic [7:0] IDX_GLOBAL_CFG = 8'h34;
    localparam logic [7:0] IDX_PREDIV_RATIO = 8'h46;
    localparam logic [7:0] IDX_LOCAL_VALID = 8'h50;
    localparam logic [7:0] IDX_LOCK_ALLOWED = 8'h51;
    localparam logic [7:0] IDX_CODE_STATUS = 8'h52;
    localparam logic [7:0] IDX_MISPROGRAM = 8'h53;

    ////////////////////////////////////////////////////////////////////////
    // Field positions

    localparam int SRC_PREDIV_BIT = 7;
    localparam int SRC_LOCK8K_BIT = 6;
    localparam int SRC_BUCKET_MSB = 5;
    localparam int SRC_BUCKET_LSB = 4;
    localparam int SRC_FREQ_MSB = 3;
    localparam int SRC_FREQ_LSB = 0;
    localparam int GLOBAL_SEL2048_BIT = 2;

    ////////////////////////////////////////////////////////////////////////
    // Reset values

    localparam logic [7:0] RST_SRC_CFG = 8'h00;
    localparam logic [7:0] RST_PARTNER_MASK_LOW = 8'hff;
    localparam logic [7:0] RST_GLOBAL_CFG = 8'h00;
    localparam logic [7:0] RST_PREDIV_RATIO = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Frequency codes

    localparam logic [3:0] CODE_8K = 4'h0;
    localparam logic [3:0] CODE_1544_2048 = 4'h1;
    localparam logic [3:0] CODE_6M48 = 4'h2;
    localparam logic [3:0] CODE_19M44 = 4'h3;
    localparam logic [3:0] CODE_25M92 = 4'h4;
    localparam logic [3:0] CODE_38M88 = 4'h5;
    localparam logic [3:0] CODE_51M84 = 4'h6;
    localparam logic [3:0] CODE_77M76 = 4'h7;
    localparam logic [3:0] CODE_155M52 = 4'h8;
    localparam logic [3:0] CODE_2K = 4'h9;
    localparam logic [3:0] CODE_4K = 4'ha;

    ////////////////////////////////////////////////////////////////////////
    // Carriers

    typedef struct packed {
        logic prediv_en;
        logic lock8k;
        logic [1:0] bucket;
        logic [3:0] freq_code;
    } rflk_src_cfg_type;

    typedef struct packed {
        logic code_ok;
        logic [HZ_WIDTH-1:0] hz;
    } rflk_freq_type;

    ////////////////////////////////////////////////////////////////////////
    // Decode of a frequency code into hertz; unused codes give zero

    function automatic rflk_freq_type rflk_decode_freq(
        input logic [3:0] code,
        input logic sel2048
    );
        rflk_freq_type f;
        f.code_ok = 1'b1;
        unique case (code)
            CODE_8K: f.hz = 28'd8000;
            CODE_1544_2048: f.hz = sel2048 ? 28'd2048000 : 28'd1544000;
            CODE_6M48: f.hz = 28'd6480000;
            CODE_19M44: f.hz = 28'd19440000;
            CODE_25M92: f.hz = 28'd25920000;
            CODE_38M88: f.hz = 28'd38880000;
            CODE_51M84: f.hz = 28'd51840000;
            CODE_77M76: f.hz = 28'd77760000;
            CODE_155M52: f.hz = 28'd155520000;
            CODE_2K: f.hz = 28'd2000;
            CODE_4K: f.hz = 28'd4000;
            default: begin
                f.code_ok = 1'b0;
                f.hz = 28'd0;
            end
        endcase
        return f;
    endfunction

endpackage

// [src/rflk_prediv.sv]
/*
 * Programmable pre-divider for one reference input, with the bypass mux
 * that feeds the DPLL and the frequency monitor.
 * Assumes ref_in is synchronous to clk and slower than half its rate.
 */
`timescale 1ns/1ps
module rflk_prediv (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ref_in,
    input wire logic prediv_en,
    input wire logic [7:0] ratio,
    output logic ref_out
);

    logic ref_q;
    logic [7:0] count;
    logic div_q;
    logic rise;

    assign rise = ref_in & ~ref_q;

    ////////////////////////////////////////////////////////////////////////
    // Edge detect and divide by twice (ratio + 1)

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= ref_in;
        end
    end

    // Divider runs only while enabled so it restarts from a known phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= 8'h00;
            div_q <= 1'b0;
        end else if (!prediv_en) begin
            count <= 8'h00;
            div_q <= 1'b0;
        end else if (rise) begin
            if (count >= ratio) begin
                count <= 8'h00;
                div_q <= ~div_q;
            end else begin
                count <= count + 8'h01;
            end
        end
    end

    // Raw path is one register late too, so switching keeps the latency
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_out <= 1'b0;
        end else begin
            ref_out <= prediv_en ? div_q : ref_q;
        end
    end

endmodule

// [src/rflk_freq_decode.sv]
/*
 * Decodes the frequency code of every input into hertz and flags codes
 * that are unused or that disagree with an enabled pre-divider.
 * Assumes the configuration words are stable register outputs.
 */
`timescale 1ns/1ps
module rflk_freq_decode (
    input wire logic clk,
    input wire logic resetn,
    input rflk_pkg::rflk_src_cfg_type cfg [rflk_pkg::NUM_INPUTS],
    input wire logic sel2048,
    output rflk_pkg::rflk_freq_type freq [rflk_pkg::NUM_INPUTS],
    output logic [rflk_pkg::NUM_INPUTS-1:0] code_unused,
    output logic [rflk_pkg::NUM_INPUTS-1:0] misprogram
);

    rflk_pkg::rflk_freq_type dec [rflk_pkg::NUM_INPUTS];

    ////////////////////////////////////////////////////////////////////////
    // Registered decode per input

    // One decode per input feeds both the rate and the unused flag
    always_comb begin
        for (int i = 0; i < rflk_pkg::NUM_INPUTS; i++) begin
            dec[i] = rflk_pkg::rflk_decode_freq(cfg[i].freq_code,
                sel2048);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < rflk_pkg::NUM_INPUTS; i++) begin
                freq[i] <= '0;
            end
            code_unused <= 8'h00;
            misprogram <= 8'h00;
        end else begin
            for (int i = 0; i < rflk_pkg::NUM_INPUTS; i++) begin
                freq[i] <= dec[i];
                code_unused[i] <= ~dec[i].code_ok;
                // Software should keep 8 kHz with the pre-divider on
                misprogram[i] <= cfg[i].prediv_en &&
                    (cfg[i].freq_code != rflk_pkg::CODE_8K);
            end
        end
    end

endmodule

// [src/rflk_top.sv]
/*
 * Reference input frequency configuration and partner-valid lock mask
 * for inputs 1 to 8, reached over a classic Wishbone slave.
 * Assumes a 40 MHz clk, active-low asynchronous resetn, reference and
 * local validity inputs synchronous to clk.
 */
// Notes on behaviour
// - Frequency codes 0 and 2 to 10 decode to fixed rates; 11-15 unused.
// - Code 1 means 1544 kHz or 2048 kHz, chosen by global bit 2.
// - Partner mask is an 8-bit read/write register, bit n for input n+1.
// - Mask bit zero forbids locking to the input despite local validity.
// - Mask bit one lets the input lock when locally qualified.
// - Pre-divider enable routes the input through it to DPLL and monitor.
`timescale 1ns/1ps
module rflk_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [rflk_pkg::ADR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [rflk_pkg::NUM_INPUTS-1:0] ref_in,
    input wire logic [rflk_pkg::NUM_INPUTS-1:0] local_valid,
    output logic [rflk_pkg::NUM_INPUTS-1:0] ref_to_dpll,
    output logic [rflk_pkg::NUM_INPUTS-1:0] lock_allowed,
    output rflk_pkg::rflk_freq_type freq [rflk_pkg::NUM_INPUTS]
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    rflk_pkg::rflk_src_cfg_type src_cfg [rflk_pkg::NUM_INPUTS];
    logic [7:0] partner_valid_mask_low;
    logic [7:0] global_cfg;
    logic [7:0] prediv_ratio;
    logic [rflk_pkg::NUM_INPUTS-1:0] code_unused;
    logic [rflk_pkg::NUM_INPUTS-1:0] misprogram;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic [7:0] idx;
    logic word_ok;
    logic req;
    logic wr_now;
    logic [7:0] next_rdata;

    assign idx = wb_adr_i[9:2];
    assign word_ok = (wb_adr_i[1:0] == 2'b00);
    assign req = wb_cyc_i & wb_stb_i;
    // Write lands on the edge where the master sees ack high
    assign wr_now = req & wb_we_i & wb_ack_o & wb_sel_i[0] & word_ok;

    function automatic logic is_src(input logic [7:0] i);
        return (i >= rflk_pkg::IDX_SRC_CFG_FIRST) &&
            (i <= rflk_pkg::IDX_SRC_CFG_LAST);
    endfunction

    function automatic logic [2:0] src_sel(input logic [7:0] i);
        logic [7:0] d;
        d = i - rflk_pkg::IDX_SRC_CFG_FIRST;
        return d[2:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge: one wait state, dropped the cycle after

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source configuration registers

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < rflk_pkg::NUM_INPUTS; i++) begin
                src_cfg[i] <= rflk_pkg::RST_SRC_CFG;
            end
        end else if (wr_now && is_src(idx)) begin
            src_cfg[src_sel(idx)] <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Partner-valid mask

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            partner_valid_mask_low <= rflk_pkg::RST_PARTNER_MASK_LOW;
        end else if (wr_now && idx == rflk_pkg::IDX_PARTNER_MASK_LOW) begin
            partner_valid_mask_low <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Global configuration and pre-divider ratio

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            global_cfg <= rflk_pkg::RST_GLOBAL_CFG;
        end else if (wr_now && idx == rflk_pkg::IDX_GLOBAL_CFG) begin
            global_cfg <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prediv_ratio <= rflk_pkg::RST_PREDIV_RATIO;
        end else if (wr_now && idx == rflk_pkg::IDX_PREDIV_RATIO) begin
            prediv_ratio <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped words read zero but are still acknowledged

    always_comb begin
        next_rdata = 8'h00;
        if (!word_ok) begin
            next_rdata = 8'h00;
        end else if (is_src(idx)) begin
            next_rdata = src_cfg[src_sel(idx)];
        end else begin
            unique case (idx)
                rflk_pkg::IDX_PARTNER_MASK_LOW:
                    next_rdata = partner_valid_mask_low;
                rflk_pkg::IDX_GLOBAL_CFG: next_rdata = global_cfg;
                rflk_pkg::IDX_PREDIV_RATIO: next_rdata = prediv_ratio;
                rflk_pkg::IDX_LOCAL_VALID: next_rdata = local_valid;
                rflk_pkg::IDX_LOCK_ALLOWED: next_rdata = lock_allowed;
                rflk_pkg::IDX_CODE_STATUS: next_rdata = code_unused;
                rflk_pkg::IDX_MISPROGRAM: next_rdata = misprogram;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Data loads with ack so it is valid on the sampling edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_ack_o) begin
            wb_dat_o <= {24'h00_0000, next_rdata};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock qualification

    // Partner veto overrides local validity; registered for a clean output
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_allowed <= 8'h00;
        end else begin
            lock_allowed <= local_valid & partner_valid_mask_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pre-dividers, one per input

    for (genvar g = 0; g < rflk_pkg::NUM_INPUTS; g++) begin : g_prediv
        rflk_prediv u_prediv (
            .clk(clk),
            .resetn(resetn),
            .ref_in(ref_in[g]),
            .prediv_en(src_cfg[g].prediv_en),
            .ratio(prediv_ratio),
            .ref_out(ref_to_dpll[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Frequency decode

    rflk_freq_decode u_decode (
        .clk(clk),
        .resetn(resetn),
        .cfg(src_cfg),
        .sel2048(global_cfg[rflk_pkg::GLOBAL_SEL2048_BIT]),
        .freq(freq),
        .code_unused(code_unused),
        .misprogram(misprogram)
    );

endmodule

// [dv/rflk_top_sva.sv]
/*
 * Checker for the reference input frequency and lock enable block.
 * Assumes it is bound to rflk_top and sees only its ports.
 */
`timescale 1ns/1ps
module rflk_top_sva (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [rflk_pkg::ADR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [rflk_pkg::NUM_INPUTS-1:0] local_valid,
    input wire logic [rflk_pkg::NUM_INPUTS-1:0] lock_allowed,
    input rflk_pkg::rflk_freq_type freq [rflk_pkg::NUM_INPUTS]
);
    ////////////////////////////////////////////////////////////////////////
    // Slice kept as a signal so that $past sees a plain name
    logic [7:0] wr_byte;
    assign wr_byte = wb_dat_i[7:0];

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_mask_wr;
        wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
            && wb_adr_i == {rflk_pkg::IDX_PARTNER_MASK_LOW, 2'h0};
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_ack_latency: assert property (s_req |=> wb_ack_o)
        else $error("ack did not follow request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_read_upper: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_unaligned_zero: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0)
        else $error("unaligned read not zero");
    a_lock_subset: assert property
        ((lock_allowed & ~$past(local_valid)) == 8'h0)
        else $error("lock allowed for locally invalid input");
    // Mask lands at the ack edge, the lock output one edge later
    a_mask_effect: assert property (s_mask_wr |-> ##2
        lock_allowed == ($past(wr_byte, 2) & $past(local_valid)))
        else $error("lock output does not follow written mask");
    a_unused_zero: assert property (
        !freq[0].code_ok |-> freq[0].hz == 28'h0)
        else $error("unused code gives a rate");
endmodule

bind rflk_top rflk_top_sva i_rflk_top_sva (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .local_valid(local_valid), .lock_allowed(lock_allowed), .freq(freq)
);

// [dv/test_ref_input_freq_and_lock_enable.sv]
/*
 * Bench for rflk_top: Wishbone tasks, mask gating, rate decode and
 * pre-divider checks.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ps
module test_ref_input_freq_and_lock_enable;
    logic clk, resetn, cyc, stb, we, ack;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, dat_o;
    logic [7:0] ref_in, lvalid, to_dpll, lock;
    rflk_pkg::rflk_freq_type freq [rflk_pkg::NUM_INPUTS];
    int fails, check_count, cycles;
    // Expected rates in hertz, indexed by code; unused codes give zero
    logic [27:0] hz_tab [16] = '{28'h1f40, 28'h178f40, 28'h62e080,
        28'h128a180, 28'h18b8200, 28'h2514300, 28'h3170400, 28'h4a28600,
        28'h9450c00, 28'h7d0, 28'hfa0, 28'h0, 28'h0, 28'h0, 28'h0, 28'h0};
    localparam logic [7:0] MASK = rflk_pkg::IDX_PARTNER_MASK_LOW;
    localparam logic [7:0] CFG1 = rflk_pkg::IDX_SRC_CFG_FIRST;

    rflk_top i_rflk_top (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .ref_in(ref_in),
        .local_valid(lvalid), .ref_to_dpll(to_dpll), .lock_allowed(lock),
        .freq(freq));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // A run of this length should end near 190 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_freq(input int i, input logic [28:0] exp);
        check_count++;
        if (freq[i] !== exp) begin
            fails++;
            $display("FAIL freq %0d expected %h seen %h", i, exp, freq[i]);
        end
    endtask

    // Called just after a rising edge; the request stands until ack
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [1:0] lo, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, lo};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            $display("FAIL ack expected 1 seen %b", ack);
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, 2'h0, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 2'h0, 8'h0);
        check($sformatf("reg %h", idx), {24'h0, exp}, rdat);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        {cyc, stb, we} = 3'h0;
        adr = 10'h0;
        sel = 4'hf;
        wdat = 32'h0;
        ref_in = 8'h0;
        lvalid = 8'h3c;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(MASK, 8'hff);
        check("lock", 32'h3c, {24'h0, lock});
        // Software drops inputs the partner reports invalid
        wr(MASK, 8'ha5);
        rd(MASK, 8'ha5);
        check("lock", 32'h24, {24'h0, lock});
        lvalid <= 8'hff;
        repeat (3) @(posedge clk);
        check("lock", 32'ha5, {24'h0, lock});
        rd(rflk_pkg::IDX_LOCAL_VALID, 8'hff);
        bus(1'b1, MASK, 2'h1, 8'h00);
        rd(MASK, 8'ha5);
        sel <= 4'he;
        wr(MASK, 8'h00);
        sel <= 4'hf;
        rd(MASK, 8'ha5);
        bus(1'b0, MASK, 2'h2, 8'h00);
        check("unaligned", 32'h0, rdat);
        rd(8'h10, 8'h00);
        rd(rflk_pkg::IDX_LOCK_ALLOWED, 8'ha5);
        $display("test mask done");
        for (int c = 0; c < 16; c++) begin
            wr(CFG1, c[7:0]);
            repeat (3) @(posedge clk);
            check_freq(0, {c < 11, hz_tab[c]});
        end
        rd(CFG1, 8'h0f);
        rd(rflk_pkg::IDX_CODE_STATUS, 8'h01);
        wr(CFG1, {4'h0, rflk_pkg::CODE_1544_2048});
        wr(rflk_pkg::IDX_GLOBAL_CFG, 8'h04);
        repeat (3) @(posedge clk);
        check_freq(0, {1'b1, 28'h1f4000});
        wr(rflk_pkg::IDX_GLOBAL_CFG, 8'h00);
        wr(rflk_pkg::IDX_SRC_CFG_LAST, {4'h0, rflk_pkg::CODE_155M52});
        repeat (3) @(posedge clk);
        check_freq(0, {1'b1, 28'h178f40});
        check_freq(7, {1'b1, 28'h9450c00});
        $display("test decode done");
        wr(CFG1 + 8'h1, 8'h82);
        rd(rflk_pkg::IDX_MISPROGRAM, 8'h02);
        ref_in <= 8'h5a;
        repeat (4) @(posedge clk);
        check("bypass", 32'h58, {24'h0, to_dpll & 8'hfd});
        // Second rising edge toggles the divided input 2 back low
        ref_in <= 8'h58;
        repeat (2) @(posedge clk);
        ref_in <= 8'h5a;
        repeat (4) @(posedge clk);
        check("divided", 32'h58, {24'h0, to_dpll});
        wr(CFG1 + 8'h1, 8'h80);
        rd(rflk_pkg::IDX_MISPROGRAM, 8'h00);
        $display("test prediv done");
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(MASK, 8'hff);
        check("lock", 32'hff, {24'h0, lock});
        $display("test reset done");
        summarize();
    end
endmodule
